// *** hius_cfg.svh ***
// Field positions, widths and reset values for the microframe scheduler
`ifndef HIUS_CFG_SVH
`define HIUS_CFG_SVH

`define HIUS_UFRAMES 8
`define HIUS_COUNT_W 12
`define HIUS_RESULT_W 3
`define HIUS_FRAME_W 5
`define HIUS_FRAME_HI 7
`define HIUS_FRAME_LO 3
`define HIUS_MASK_RESET 8'h00
`define HIUS_COUNT_RESET 12'h000
`define HIUS_RESULT_RESET 3'h0
`define HIUS_RES_ERR_BIT 0
`define HIUS_RES_BABBLE_BIT 1
`define HIUS_RES_UNDERRUN_BIT 2
`define HIUS_W45_MASK_LSB 0
`define HIUS_W45_RES_LSB 8
`define HIUS_W45_CNT0_LSB 32
`define HIUS_W45_CNT1_LSB 44
`define HIUS_W45_CNT2LO_LSB 56
`define HIUS_W67_CNT2HI_LSB 0
`define HIUS_W67_CNT3_LSB 4
`define HIUS_W67_CNT4_LSB 16
`define HIUS_W67_CNT5_LSB 28
`define HIUS_W67_CNT6_LSB 40
`define HIUS_W67_CNT7_LSB 52

`endif

// *** hius_pkg.sv ***
// Types shared by the microframe scheduler and its descriptor packer
`include "hius_cfg.svh"
package hius_pkg;
  typedef logic [`HIUS_COUNT_W-1:0] hius_count_t;
  typedef logic [`HIUS_RESULT_W-1:0] hius_result_t;

  // Outcome of one bus transaction, returned by the link side
  typedef struct packed {
    hius_count_t byte_count;
    logic is_in;
    logic xact_err;
    logic babble;
    logic underrun;
    logic halted;
  } hius_done_t;

  typedef enum logic [2:0] {
    HIUS_IDLE = 3'b001,
    HIUS_ISSUE = 3'b010,
    HIUS_WAIT = 3'b100
  } hius_state_t;
endpackage

// *** hius_desc_pack.sv ***
// Packs per-microframe counts, results and the activation mask into descriptor words
`timescale 1ns/1ps
`default_nettype none
`include "hius_cfg.svh"
module hius_desc_pack (
  input wire logic [8*`HIUS_COUNT_W-1:0] counts, // Count k at bits 12k+11..12k
  input wire logic [8*`HIUS_RESULT_W-1:0] results, // Result k at bits 3k+2..3k
  input wire logic [7:0] mask, // Activation mask
  output logic [63:0] word_45, // Descriptor words 4 (low) and 5 (high)
  output logic [63:0] word_67 // Descriptor words 6 (low) and 7 (high)
);
  import hius_pkg::*;

  hius_count_t cnt [8];

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      cnt[k] = counts[k*`HIUS_COUNT_W +: `HIUS_COUNT_W];
    end
  end

  always_comb begin
    word_45 = 64'h0000_0000_0000_0000;
    word_45[`HIUS_W45_MASK_LSB +: 8] = mask;
    word_45[`HIUS_W45_RES_LSB +: 8*`HIUS_RESULT_W] = results;
    word_45[`HIUS_W45_CNT0_LSB +: 12] = cnt[0];
    word_45[`HIUS_W45_CNT1_LSB +: 12] = cnt[1];
    word_45[`HIUS_W45_CNT2LO_LSB +: 8] = cnt[2][7:0];
  end

  always_comb begin
    word_67 = 64'h0000_0000_0000_0000;
    word_67[`HIUS_W67_CNT2HI_LSB +: 4] = cnt[2][11:8];
    word_67[`HIUS_W67_CNT3_LSB +: 12] = cnt[3];
    word_67[`HIUS_W67_CNT4_LSB +: 12] = cnt[4];
    word_67[`HIUS_W67_CNT5_LSB +: 4] = cnt[5][3:0];
    word_67[`HIUS_W67_CNT5_LSB+4 +: 8] = cnt[5][11:4];
    word_67[`HIUS_W67_CNT6_LSB +: 12] = cnt[6];
    word_67[`HIUS_W67_CNT7_LSB +: 12] = cnt[7];
  end
endmodule
`default_nettype wire

// *** hius_sched.sv ***
// High-speed interrupt microframe scheduler with per-microframe result storage
`timescale 1ns/1ps
`default_nettype none
`include "hius_cfg.svh"
module hius_sched (
  input wire logic core_clk, // 20 MHz clock
  input wire logic reset, // Asynchronous, active high
  input wire logic [7:0] descriptor_word2, // Low byte of descriptor word 2
  input wire logic [7:0] mask_set, // Software mask bit set, one-cycle pulse
  input wire logic halt_clear, // Software clears halt, one-cycle pulse
  input wire logic [4:0] bus_frame, // Current bus frame number
  input wire logic usof_strobe, // Start of microframe, one-cycle pulse
  input wire logic [2:0] usof_index, // Microframe number within the frame
  output logic txn_req, // Issue a transaction, one-cycle pulse
  output logic [2:0] txn_uframe, // Microframe of the issued transaction
  input wire logic txn_done, // Transaction finished, one-cycle pulse
  input wire hius_pkg::hius_done_t txn_result, // Outcome, valid with txn_done
  output logic busy, // A transaction is outstanding
  output logic [7:0] uframe_activation_mask, // Activation mask
  output logic halt, // Descriptor halted
  output logic [63:0] word_45, // Descriptor words 4 and 5 image
  output logic [63:0] word_67 // Descriptor words 6 and 7 image
);
  import hius_pkg::*;

  hius_state_t state;
  hius_count_t cnt [8];
  hius_result_t res [8];
  logic [2:0] pend;
  logic [4:0] desc_frame;
  logic frame_match;
  logic launch;
  logic accept;
  logic [7:0] hw_clear;
  logic [8*`HIUS_COUNT_W-1:0] counts_flat;
  logic [8*`HIUS_RESULT_W-1:0] results_flat;

  function automatic logic [7:0] uframe_bit(input logic [2:0] idx);
    uframe_bit = 8'h01 << idx;
  endfunction

  // Frame field; a microframe is serviced only when it equals bus_frame, then gated by the mask
  assign desc_frame = descriptor_word2[`HIUS_FRAME_HI:`HIUS_FRAME_LO];
  assign frame_match = (desc_frame == bus_frame);
  assign launch = (state == HIUS_IDLE) && usof_strobe && frame_match && !halt
    && ((uframe_activation_mask & uframe_bit(usof_index)) != 8'h00);
  assign accept = (state == HIUS_WAIT) && txn_done;
  assign hw_clear = accept ? uframe_bit(pend) : 8'h00;
  assign busy = (state != HIUS_IDLE);

  // Strobes arriving while a transaction is pending are dropped on purpose
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= HIUS_IDLE;
    end else begin
      case (state)
        HIUS_IDLE: begin
          if (launch) begin
            state <= HIUS_ISSUE;
          end
        end
        HIUS_ISSUE: begin
          state <= HIUS_WAIT;
        end
        HIUS_WAIT: begin
          if (txn_done) begin
            state <= HIUS_IDLE;
          end
        end
        default: begin
          state <= HIUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend <= 3'h0;
      txn_req <= 1'b0;
      txn_uframe <= 3'h0;
    end else begin
      txn_req <= launch;
      if (launch) begin
        pend <= usof_index;
        txn_uframe <= usof_index;
      end
    end
  end

  // A software set in the same cycle as the hardware clear wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      uframe_activation_mask <= `HIUS_MASK_RESET;
    end else begin
      uframe_activation_mask <= (uframe_activation_mask & ~hw_clear) | mask_set;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      halt <= 1'b0;
    end else if (accept && txn_result.halted) begin
      halt <= 1'b1;
    end else if (halt_clear) begin
      halt <= 1'b0;
    end
  end

  // Only the serviced microframe is touched; all others hold
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 8; k++) begin
        cnt[k] <= `HIUS_COUNT_RESET;
        res[k] <= `HIUS_RESULT_RESET;
      end
    end else if (accept) begin
      cnt[pend] <= txn_result.byte_count;
      res[pend][`HIUS_RES_ERR_BIT] <= txn_result.xact_err;
      res[pend][`HIUS_RES_BABBLE_BIT] <= txn_result.babble && txn_result.is_in;
      res[pend][`HIUS_RES_UNDERRUN_BIT] <= txn_result.underrun && !txn_result.is_in;
    end
  end

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      counts_flat[k*`HIUS_COUNT_W +: `HIUS_COUNT_W] = cnt[k];
      results_flat[k*`HIUS_RESULT_W +: `HIUS_RESULT_W] = res[k];
    end
  end

  hius_desc_pack u_pack (
    .counts(counts_flat),
    .results(results_flat),
    .mask(uframe_activation_mask),
    .word_45(word_45),
    .word_67(word_67)
  );

  issue_on_mask_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (state == HIUS_IDLE && usof_strobe && frame_match && !halt
      && uframe_activation_mask[usof_index])
    |=> (txn_req && txn_uframe == $past(usof_index)))
    else $error("masked microframe not issued");

  no_issue_unmasked_a: assert property (
    @(posedge core_clk) disable iff (reset)
    txn_req |-> $past(uframe_activation_mask[usof_index]) && $past(usof_strobe))
    else $error("transaction issued without mask bit");

  frame_gate_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (usof_strobe && desc_frame != bus_frame) |=> !txn_req)
    else $error("transaction issued in unmatched frame");

  mask_clear_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (accept && !mask_set[pend]) |=> !uframe_activation_mask[$past(pend)])
    else $error("serviced mask bit not cleared");

  mask_rise_a: assert property (
    @(posedge core_clk) disable iff (reset)
    ((uframe_activation_mask & ~$past(uframe_activation_mask)) & ~$past(mask_set)) == 8'h00)
    else $error("mask bit set by hardware");

  mask_fall_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (!accept) |=> (($past(uframe_activation_mask) & ~uframe_activation_mask) == 8'h00))
    else $error("mask bit cleared without servicing");

  count_write_a: assert property (
    @(posedge core_clk) disable iff (reset)
    accept |=> cnt[$past(pend)] == $past(txn_result.byte_count))
    else $error("byte count not stored");

  error_bit_a: assert property (
    @(posedge core_clk) disable iff (reset)
    accept |=> res[$past(pend)][0] == $past(txn_result.xact_err))
    else $error("transaction error bit wrong");

  babble_in_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (accept && !txn_result.is_in) |=> !res[$past(pend)][1])
    else $error("babble reported on OUT");

  underrun_out_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (accept && txn_result.is_in) |=> !res[$past(pend)][2])
    else $error("underrun reported on IN");

  result_after_done_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (results_flat != $past(results_flat)) |-> $past(accept))
    else $error("result written before completion");

  fields_hold_a: assert property (
    @(posedge core_clk) disable iff (reset)
    !accept |=> $stable(counts_flat) && $stable(results_flat))
    else $error("unserviced fields changed");

  halt_set_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (accept && txn_result.halted) |=> halt ##1 !txn_req)
    else $error("halt not taken");

  halt_block_a: assert property (
    @(posedge core_clk) disable iff (reset)
    halt |=> !txn_req)
    else $error("issued while halted");

  split_nibble_a: assert property (
    @(posedge core_clk) disable iff (reset)
    word_67[31:28] == cnt[5][3:0] && word_67[3:0] == cnt[2][11:8])
    else $error("straddled count misplaced");

  cnt2_low_a: assert property (
    @(posedge core_clk) disable iff (reset)
    word_45[63:56] == cnt[2][7:0])
    else $error("count 2 low byte misplaced");

  result_pack_a: assert property (
    @(posedge core_clk) disable iff (reset)
    word_45[31:29] == res[7] && word_45[10:8] == res[0])
    else $error("result fields misplaced");
endmodule
`default_nettype wire

// *** hius_ep_model.sv ***
// Behavioural interrupt endpoint that answers each issued transaction once
`timescale 1ns/1ps
`default_nettype none
module hius_ep_model (
  input wire logic core_clk, // Clock
  input wire logic reset, // Active high
  input wire logic txn_req, // Issue pulse from the scheduler
  input wire logic [3:0] delay, // Extra cycles before the answer
  input wire hius_pkg::hius_done_t res_in, // Outcome to hand back
  output logic txn_done, // Completion pulse
  output hius_pkg::hius_done_t txn_result // Outcome, valid with txn_done
);
  import hius_pkg::*;
  int cnt;
  // Exactly one answer per request, never in the request cycle itself
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      txn_done <= 1'b0;
    end else begin
      txn_done <= (cnt == 1);
      if (txn_req) begin
        cnt <= int'(delay) + 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Outside completion the result lines carry junk so stale values never pass
  assign txn_result = txn_done ? res_in : ~res_in;
endmodule
`default_nettype wire

// *** hius_sched_tb_top.sv ***
// Self-checking bench for the microframe scheduler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t value differs", $time); end end
module hius_sched_tb_top;
  import hius_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] descriptor_word2 = 8'h00;
  logic [7:0] mask_set = 8'h00;
  logic halt_clear = 1'b0;
  logic [4:0] bus_frame = 5'h0b;
  logic usof_strobe = 1'b0;
  logic [2:0] usof_index = 3'h0;
  logic txn_req, txn_done, busy, halt;
  logic [2:0] txn_uframe;
  hius_done_t txn_result;
  hius_done_t res_in = '0;
  logic [3:0] delay = 4'h0;
  logic [7:0] uframe_activation_mask;
  logic [63:0] word_45, word_67;
  logic [15:0] seed = 16'h002b;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [11:0] m_cnt [8];
  logic [2:0] m_res [8];
  logic [7:0] m_mask = 8'h00;
  logic m_halt = 1'b0;

  always #25 core_clk = ~core_clk;

  hius_sched u_dut (.core_clk(core_clk), .reset(reset), .descriptor_word2(descriptor_word2),
    .mask_set(mask_set), .halt_clear(halt_clear), .bus_frame(bus_frame),
    .usof_strobe(usof_strobe), .usof_index(usof_index), .txn_req(txn_req),
    .txn_uframe(txn_uframe), .txn_done(txn_done), .txn_result(txn_result), .busy(busy),
    .uframe_activation_mask(uframe_activation_mask), .halt(halt), .word_45(word_45),
    .word_67(word_67));
  hius_ep_model u_ep (.core_clk(core_clk), .reset(reset), .txn_req(txn_req), .delay(delay),
    .res_in(res_in), .txn_done(txn_done), .txn_result(txn_result));

  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: a full run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task automatic check_words();
    logic [63:0] w45;
    logic [63:0] w67;
    w45 = {m_cnt[2][7:0], m_cnt[1], m_cnt[0], 24'h00_0000, m_mask};
    for (int k = 0; k < 8; k++) begin
      w45[8 + 3 * k +: 3] = m_res[k];
    end
    w67 = {m_cnt[7], m_cnt[6], m_cnt[5], m_cnt[4], m_cnt[3], m_cnt[2][11:8]};
    `CHK(word_45[63:32], w45[63:32])
    `CHK(word_45[31:8], w45[31:8])
    `CHK(word_67, w67)
    `CHK(uframe_activation_mask, m_mask)
    `CHK(halt, m_halt)
  endtask

  task automatic set_mask(input logic [7:0] m);
    @(negedge core_clk);
    mask_set = m;
    @(negedge core_clk);
    mask_set = 8'h00;
    m_mask = m_mask | m;
    check_words();
  endtask

  // One microframe start; the model decides whether a transaction must follow
  task automatic strobe(input logic [2:0] k, input logic frame_ok, input logic stop);
    hius_done_t r;
    logic [15:0] s;
    logic go;
    int t;
    s = rnd();
    r.byte_count = s[11:0];
    r.is_in = s[12];
    r.xact_err = s[13];
    r.babble = s[14];
    r.underrun = s[15];
    r.halted = stop;
    go = frame_ok && !m_halt && m_mask[k];
    @(negedge core_clk);
    res_in = r;
    delay = s[7:4];
    descriptor_word2 = {frame_ok ? bus_frame : ~bus_frame, s[2:0]};
    usof_strobe = 1'b1;
    usof_index = k;
    @(negedge core_clk);
    usof_strobe = 1'b0;
    `CHK(txn_req, go)
    if (go) begin
      `CHK(txn_uframe, k)
      `CHK(busy, 1'b1)
      t = 0;
      // A second strobe for the same set bit while busy must be dropped
      while (busy === 1'b1 && t < 40) begin
        @(negedge core_clk);
        t++;
        usof_strobe = (t == 1);
        `CHK(txn_req, 1'b0)
      end
      `CHK(busy, 1'b0)
      m_cnt[k] = r.byte_count;
      m_res[k] = {!r.is_in && r.underrun, r.is_in && r.babble, r.xact_err};
      m_mask[k] = 1'b0;
      m_halt = m_halt | stop;
    end
    check_words();
  endtask

  initial begin
    for (int k = 0; k < 8; k++) begin
      m_cnt[k] = 12'h000;
      m_res[k] = 3'h0;
    end
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    check_words();
    set_mask(8'hff);
    for (int k = 0; k < 8; k++) begin
      strobe(3'(k), 1'b1, 1'b0);
    end
    set_mask(8'h55);
    for (int k = 0; k < 8; k++) begin
      strobe(3'(k), 1'b1, 1'b0);
    end
    // Mismatched frame first, then the same mask in the right frame
    set_mask(8'h88);
    for (int k = 0; k < 16; k++) begin
      strobe(3'(k), k > 7, 1'b0);
    end
    set_mask(8'h03);
    strobe(3'h0, 1'b1, 1'b1);
    strobe(3'h1, 1'b1, 1'b0);
    @(negedge core_clk);
    halt_clear = 1'b1;
    @(negedge core_clk);
    halt_clear = 1'b0;
    m_halt = 1'b0;
    strobe(3'h1, 1'b1, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
